// ===== hdl/tap_regs.svh
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// -----------------------------------------------------------------
// instruction register
// -----------------------------------------------------------------
`define IR_WIDTH 4
`define IR_EXTEST 4'h0
`define IR_IDCODE 4'h1
`define IR_HIGHZ 4'h4
`define IR_SAMPLE 4'h5
`define IR_INTEST 4'h6
`define IR_CLAMP 4'h7
`define IR_BYPASS 4'hf
`define IR_CAPTURE 4'h1
`define IR_RESET `IR_IDCODE

// -----------------------------------------------------------------
// identification word fields
// -----------------------------------------------------------------
`define ID_WIDTH 32
`define ID_VER_WIDTH 4
`define ID_DEV_WIDTH 16
`define ID_MFR_WIDTH 11
`define ID_LSB 1'h1

// -----------------------------------------------------------------
// processor port
// -----------------------------------------------------------------
`define ADDR_WIDTH 5
`define ADDR_PORT_MASK 5'h1b
`define ADDR_ID_HOLDER 5'h1c
`define PORT_MASK_RESET 8'hff
`define ID_HOLDER_CLEAR 8'h00
`define READ_UNMAPPED 8'h00

`endif

// ===== hdl/tap_pkg.sv
package tap_pkg;

  typedef enum logic [3:0] {
    test_logic_reset,
    run_test_idle,
    select_dr,
    capture_dr,
    shift_dr,
    exit1_dr,
    pause_dr,
    exit2_dr,
    update_dr,
    select_ir,
    capture_ir,
    shift_ir,
    exit1_ir,
    pause_ir,
    exit2_ir,
    update_ir
  } tap_state_type;

endpackage

// ===== hdl/boundary_cell.sv
module boundary_cell (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic i_update,
  input wire logic i_cap_data,
  input wire logic i_ser_in,
  output logic o_ser_out,
  output logic o_upd_data
);

  logic shift_reg;
  logic upd_reg;

  // -----------------------------------------------------------------
  // shift stage and holding stage
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      shift_reg <= 1'b0;
    end else if (i_capture) begin
      shift_reg <= i_cap_data;
    end else if (i_shift) begin
      shift_reg <= i_ser_in;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      upd_reg <= 1'b0;
    end else if (i_update) begin
      upd_reg <= shift_reg;
    end
  end

  assign o_ser_out = shift_reg;
  assign o_upd_data = upd_reg;

endmodule

// ===== hdl/boundary_scan_tap.sv
`include "tap_regs.svh"
// Overview of operation
// - standard tap state machine stepped by tms
// - test logic sequenced by test clock edges
// - tdi shifted in on rising test clock
// - tdo driven only in shift states
// - trst forces tap reset asynchronously
// - four bit instruction register
// - instruction codes decoded as listed
// - extest drives pins, captures pin inputs
// - intest drives core inputs, captures core outputs
// - sample captures pins without disturbing core
// - update stage drives pins in test mode
// - idcode shifts 32-bit identification word
// - clamp holds pins, bypass, no update
// - highz floats outputs from update-ir
// - bypass gives one test clock delay
// - one, two, three cells per pin kind
// - id holder loaded at hardware reset
// - 8-bit mode: first mask write clears
// - 16-bit mode: id holder never cleared
// - width pin high selects 16-bit mode
// - id holder at 1c, mask at 1b
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int NUM_IN = 2,
  parameter int NUM_OUT = 2,
  parameter int NUM_BIDIR = 2,
  // identification values are arbitrary
  parameter logic [3:0] ID_VERSION = 4'h5,
  parameter logic [15:0] ID_DEVICE = 16'h00a3,
  parameter logic [10:0] ID_MFR = 11'h155
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [NUM_IN-1:0] i_pad_in,
  output logic [NUM_IN-1:0] o_core_in,
  input wire logic [NUM_OUT-1:0] i_core_out,
  input wire logic [NUM_OUT-1:0] i_core_oe,
  output logic [NUM_OUT-1:0] o_pad_out,
  output logic [NUM_OUT-1:0] o_pad_oe,
  input wire logic [NUM_BIDIR-1:0] i_pad_bi_in,
  output logic [NUM_BIDIR-1:0] o_core_bi_in,
  input wire logic [NUM_BIDIR-1:0] i_core_bi_out,
  input wire logic [NUM_BIDIR-1:0] i_core_bi_oe,
  output logic [NUM_BIDIR-1:0] o_pad_bi_out,
  output logic [NUM_BIDIR-1:0] o_pad_bi_oe,
  input wire logic i_bus_width_select,
  input wire logic [`ADDR_WIDTH-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);

  localparam int OUT_BASE = NUM_IN;
  localparam int BI_BASE = NUM_IN + 2 * NUM_OUT;
  localparam int NUM_CELLS = NUM_IN + 2 * NUM_OUT + 3 * NUM_BIDIR;
  localparam logic [`ID_WIDTH-1:0] ID_WORD =
    {ID_VERSION, ID_DEVICE, ID_MFR, `ID_LSB};
  localparam logic [7:0] ID_SHORT = {ID_VERSION, ID_DEVICE[3:0]};

  // -----------------------------------------------------------------
  // pin synchronisers and test clock edges
  // -----------------------------------------------------------------
  localparam int SYNC_W = 3 + NUM_IN + NUM_BIDIR + 1;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic tck_prev_reg;
  wire tck_s = sync2_reg[0];
  wire tms_s = sync2_reg[1];
  wire tdi_s = sync2_reg[2];
  wire [NUM_IN-1:0] pad_in_s = sync2_reg[3 +: NUM_IN];
  wire [NUM_BIDIR-1:0] pad_bi_s = sync2_reg[3 + NUM_IN +: NUM_BIDIR];
  wire width16_s = sync2_reg[SYNC_W-1];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {i_bus_width_select, i_pad_bi_in, i_pad_in,
                    i_tdi, i_tms, i_tck};
      sync2_reg <= sync1_reg;
      tck_prev_reg <= tck_s;
    end
  end

  // sequencing only on test clock edges
  wire tck_rise = tck_s & ~tck_prev_reg;
  wire tck_fall = ~tck_s & tck_prev_reg;

  // -----------------------------------------------------------------
  // tap state machine
  // -----------------------------------------------------------------
  tap_state_type state_reg;
  tap_state_type state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      test_logic_reset: state_next = tms_s ? test_logic_reset
                                           : run_test_idle;
      run_test_idle: state_next = tms_s ? select_dr : run_test_idle;
      select_dr: state_next = tms_s ? select_ir : capture_dr;
      capture_dr: state_next = tms_s ? exit1_dr : shift_dr;
      shift_dr: state_next = tms_s ? exit1_dr : shift_dr;
      exit1_dr: state_next = tms_s ? update_dr : pause_dr;
      pause_dr: state_next = tms_s ? exit2_dr : pause_dr;
      exit2_dr: state_next = tms_s ? update_dr : shift_dr;
      update_dr: state_next = tms_s ? select_dr : run_test_idle;
      select_ir: state_next = tms_s ? test_logic_reset : capture_ir;
      capture_ir: state_next = tms_s ? exit1_ir : shift_ir;
      shift_ir: state_next = tms_s ? exit1_ir : shift_ir;
      exit1_ir: state_next = tms_s ? update_ir : pause_ir;
      pause_ir: state_next = tms_s ? exit2_ir : pause_ir;
      exit2_ir: state_next = tms_s ? update_ir : shift_ir;
      update_ir: state_next = tms_s ? select_dr : run_test_idle;
      default: state_next = test_logic_reset;
    endcase
  end

  // trst resets the tap without any clock edge
  always_ff @(posedge i_ref_clk or negedge i_trst_n) begin
    if (!i_trst_n) begin
      state_reg <= test_logic_reset;
    end else if (i_rst) begin
      state_reg <= test_logic_reset;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  wire st_tlr = (state_reg == test_logic_reset);
  wire st_cap_dr = (state_reg == capture_dr);
  wire st_shift_dr = (state_reg == shift_dr);
  wire st_upd_dr = (state_reg == update_dr);
  wire st_cap_ir = (state_reg == capture_ir);
  wire st_shift_ir = (state_reg == shift_ir);
  wire st_upd_ir = (state_reg == update_ir);

  // -----------------------------------------------------------------
  // instruction register
  // -----------------------------------------------------------------
  logic [`IR_WIDTH-1:0] ir_shift_reg;
  logic [`IR_WIDTH-1:0] ir_active_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ir_shift_reg <= `IR_CAPTURE;
    end else if (tck_rise && st_cap_ir) begin
      ir_shift_reg <= `IR_CAPTURE;
    end else if (tck_rise && st_shift_ir) begin
      ir_shift_reg <= {tdi_s, ir_shift_reg[`IR_WIDTH-1:1]};
    end
  end

  // new instruction takes effect at update-ir
  always_ff @(posedge i_ref_clk or negedge i_trst_n) begin
    if (!i_trst_n) begin
      ir_active_reg <= `IR_RESET;
    end else if (i_rst || st_tlr) begin
      ir_active_reg <= `IR_RESET;
    end else if (tck_fall && st_upd_ir) begin
      ir_active_reg <= ir_shift_reg;
    end
  end

  wire ins_extest = (ir_active_reg == `IR_EXTEST);
  wire ins_idcode = (ir_active_reg == `IR_IDCODE);
  wire ins_highz = (ir_active_reg == `IR_HIGHZ);
  wire ins_sample = (ir_active_reg == `IR_SAMPLE);
  wire ins_intest = (ir_active_reg == `IR_INTEST);
  wire ins_clamp = (ir_active_reg == `IR_CLAMP);
  wire sel_bsr = ins_extest | ins_sample | ins_intest;
  // clamp, highz and unknown codes use bypass
  wire sel_bypass = ~sel_bsr & ~ins_idcode;
  // pins follow holding stage in test mode
  wire pin_test = ins_extest | ins_clamp | ins_intest;

  // -----------------------------------------------------------------
  // identification and bypass data registers
  // -----------------------------------------------------------------
  logic [`ID_WIDTH-1:0] id_shift_reg;
  logic bypass_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      id_shift_reg <= ID_WORD;
    end else if (tck_rise && st_cap_dr && ins_idcode) begin
      id_shift_reg <= ID_WORD;
    end else if (tck_rise && st_shift_dr && ins_idcode) begin
      id_shift_reg <= {tdi_s, id_shift_reg[`ID_WIDTH-1:1]};
    end
  end

  // single stage between tdi and tdo
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && st_cap_dr && sel_bypass) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && st_shift_dr && sel_bypass) begin
      bypass_reg <= tdi_s;
    end
  end

  // -----------------------------------------------------------------
  // boundary chain, cell 0 nearest tdo
  // -----------------------------------------------------------------
  logic [NUM_CELLS-1:0] cap_vec;
  logic [NUM_CELLS-1:0] ser_vec;
  logic [NUM_CELLS-1:0] upd_vec;
  // capture and shift only with boundary selected
  wire bsr_cap = tck_rise & st_cap_dr & sel_bsr;
  // tdi enters on rising test clock
  wire bsr_shift = tck_rise & st_shift_dr & sel_bsr;
  // clamp never reaches the update stage
  wire bsr_upd = tck_fall & st_upd_dr & sel_bsr;

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_in
      assign cap_vec[g] = pad_in_s[g];
    end
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      assign cap_vec[OUT_BASE + 2 * g] = i_core_out[g];
      assign cap_vec[OUT_BASE + 2 * g + 1] = i_core_oe[g];
    end
    for (g = 0; g < NUM_BIDIR; g++) begin : g_bi
      assign cap_vec[BI_BASE + 3 * g] = pad_bi_s[g];
      assign cap_vec[BI_BASE + 3 * g + 1] = i_core_bi_out[g];
      assign cap_vec[BI_BASE + 3 * g + 2] = i_core_bi_oe[g];
    end
    for (g = 0; g < NUM_CELLS; g++) begin : g_cell
      wire ser_in = (g == NUM_CELLS - 1) ? tdi_s : ser_vec[(g + 1) %
                    NUM_CELLS];
      boundary_cell u_cell (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_capture(bsr_cap),
        .i_shift(bsr_shift),
        .i_update(bsr_upd),
        .i_cap_data(cap_vec[g]),
        .i_ser_in(ser_in),
        .o_ser_out(ser_vec[g]),
        .o_upd_data(upd_vec[g])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // pin and core multiplexers
  // -----------------------------------------------------------------
  logic [NUM_OUT-1:0] out_upd;
  logic [NUM_OUT-1:0] oe_upd;
  logic [NUM_BIDIR-1:0] bi_in_upd;
  logic [NUM_BIDIR-1:0] bi_out_upd;
  logic [NUM_BIDIR-1:0] bi_oe_upd;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_osel
      assign out_upd[g] = upd_vec[OUT_BASE + 2 * g];
      assign oe_upd[g] = upd_vec[OUT_BASE + 2 * g + 1];
    end
    for (g = 0; g < NUM_BIDIR; g++) begin : g_bsel
      assign bi_in_upd[g] = upd_vec[BI_BASE + 3 * g];
      assign bi_out_upd[g] = upd_vec[BI_BASE + 3 * g + 1];
      assign bi_oe_upd[g] = upd_vec[BI_BASE + 3 * g + 2];
    end
  endgenerate

  // holding stage drives the pins under test
  wire [NUM_OUT-1:0] pad_out_next = pin_test ? out_upd : i_core_out;
  wire [NUM_BIDIR-1:0] pad_bi_out_next =
    pin_test ? bi_out_upd : i_core_bi_out;
  wire [NUM_OUT-1:0] pad_oe_next =
    ins_highz ? '0 : (pin_test ? oe_upd : i_core_oe);
  wire [NUM_BIDIR-1:0] pad_bi_oe_next =
    ins_highz ? '0 : (pin_test ? bi_oe_upd : i_core_bi_oe);
  // intest feeds core inputs from the cells
  wire [NUM_IN-1:0] core_in_next =
    ins_intest ? upd_vec[NUM_IN-1:0] : pad_in_s;
  wire [NUM_BIDIR-1:0] core_bi_next = ins_intest ? bi_in_upd : pad_bi_s;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pad_out <= '0;
      o_pad_oe <= '0;
      o_pad_bi_out <= '0;
      o_pad_bi_oe <= '0;
      o_core_in <= '0;
      o_core_bi_in <= '0;
    end else begin
      o_pad_out <= pad_out_next;
      o_pad_oe <= pad_oe_next;
      o_pad_bi_out <= pad_bi_out_next;
      o_pad_bi_oe <= pad_bi_oe_next;
      o_core_in <= core_in_next;
      o_core_bi_in <= core_bi_next;
    end
  end

  // -----------------------------------------------------------------
  // test data output
  // -----------------------------------------------------------------
  wire dr_out = sel_bsr ? ser_vec[0] :
                (ins_idcode ? id_shift_reg[0] : bypass_reg);
  wire tdo_next = st_shift_ir ? ir_shift_reg[0] : dr_out;

  // change on falling edge, float outside shift
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || st_tlr) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo <= tdo_next;
      o_tdo_oe <= st_shift_ir | st_shift_dr;
    end
  end

  // -----------------------------------------------------------------
  // processor port: identification holder and mask
  // -----------------------------------------------------------------
  logic [7:0] id_holder_reg;
  logic [7:0] port_mask_reg;
  logic mask_written_reg;
  wire hit_mask = (i_addr == `ADDR_PORT_MASK);
  wire hit_id = (i_addr == `ADDR_ID_HOLDER);
  wire mask_wr = i_wr & hit_mask;
  // width pin high means 16-bit port
  wire width16 = width16_s;
  // first mask write in 8-bit mode clears
  wire id_clear = mask_wr & ~width16 & ~mask_written_reg;
  wire [7:0] rd_mux = hit_id ? id_holder_reg :
                      (hit_mask ? port_mask_reg : `READ_UNMAPPED);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      id_holder_reg <= ID_SHORT;
      port_mask_reg <= `PORT_MASK_RESET;
      mask_written_reg <= 1'b0;
      o_rdata <= `READ_UNMAPPED;
    end else begin
      // 16-bit mode leaves the holder alone
      if (id_clear) begin
        id_holder_reg <= `ID_HOLDER_CLEAR;
      end
      if (mask_wr) begin
        port_mask_reg <= i_wdata;
        mask_written_reg <= 1'b1;
      end
      if (i_rd) begin
        o_rdata <= rd_mux;
      end
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_trst_forces_reset: assert property (
    !i_trst_n |=> state_reg == test_logic_reset)
    else $error("tap not in reset under trst");
  a_tms_leaves_reset: assert property (
    tck_rise && st_tlr && !tms_s && i_trst_n ##1 i_trst_n
    |-> state_reg == run_test_idle)
    else $error("tap did not leave reset on tms low");
  a_tdo_floats: assert property (
    tck_fall && !st_shift_ir && !st_shift_dr |=> !o_tdo_oe)
    else $error("tdo driven outside shift state");
  a_tdo_drives_dr: assert property (
    tck_fall && st_shift_dr && !st_tlr |=> o_tdo_oe && o_tdo == $past(dr_out))
    else $error("tdo wrong in shift-dr");
  a_ir_update_load: assert property (
    tck_fall && st_upd_ir && i_trst_n ##1 i_trst_n
    |-> ir_active_reg == $past(ir_shift_reg))
    else $error("instruction not loaded at update-ir");
  a_bypass_one_stage: assert property (
    tck_rise && st_shift_dr && sel_bypass |=> bypass_reg == $past(tdi_s))
    else $error("bypass stage wrong");
  a_idcode_capture: assert property (
    tck_rise && st_cap_dr && ins_idcode |=> id_shift_reg == ID_WORD &&
    id_shift_reg[0] == 1'b1)
    else $error("identification word not captured");
  a_highz_outputs: assert property (
    ins_highz ##1 ins_highz |=> o_pad_oe == '0 && o_pad_bi_oe == '0)
    else $error("outputs not floated under highz");
  a_clamp_keeps_cells: assert property (
    tck_fall && st_upd_dr && ins_clamp |=> upd_vec == $past(upd_vec))
    else $error("holding stage changed under clamp");
  a_extest_pins: assert property (
    ins_extest ##1 ins_extest |=> o_pad_out == $past(out_upd))
    else $error("pins not driven from cells under extest");
  a_id_first_clear: assert property (
    id_clear |=> id_holder_reg == `ID_HOLDER_CLEAR)
    else $error("holder not cleared by first mask write");
  a_id_kept_wide: assert property (
    mask_wr && width16 |=> id_holder_reg == $past(id_holder_reg))
    else $error("holder changed in 16-bit mode");
  a_id_readback: assert property (
    i_rd && hit_id |=> o_rdata == $past(id_holder_reg))
    else $error("holder read wrong");

  c_idcode_shift: cover property (tck_rise && st_shift_dr && ins_idcode);
  c_extest_update: cover property (bsr_upd && ins_extest);
  c_id_cleared: cover property (id_clear);
  c_highz_active: cover property (ins_highz && o_pad_oe == '0);

endmodule

// ===== sim/jtag_tester.sv
module jtag_tester (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end

  // ---------------------------------------------------------------
  // one test clock cycle, 400 ns
  // ---------------------------------------------------------------
  // tms, tdi set while tck low, held past the fall
  task automatic step(input logic tms, input logic tdi,
                      output logic tdo);
    #100;
    o_tms = tms;
    o_tdi = tdi;
    #100;
    o_tck = 1'b1;
    #100;
    // undriven tdo reads as high impedance
    tdo = i_tdo_oe ? i_tdo : 1'bz;
    #100;
    o_tck = 1'b0;
  endtask

  // tck stands still across the reset pulse
  task automatic pulse_reset();
    o_trst_n = 1'b0;
    #300;
    o_trst_n = 1'b1;
    #300;
  endtask
endmodule

// ===== sim/boundary_scan_tap_tb_top.sv
module boundary_scan_tap_tb_top;
  import tap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // identification values are arbitrary
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] DEV = 16'h0c4b;
  localparam logic [10:0] MFR = 11'h2a9;
  localparam logic [31:0] ID_EXP = {VER, DEV, MFR, 1'b1};
  localparam logic [7:0] ID8 = {VER, DEV[3:0]};
  localparam logic [11:0] PRE = 12'ha5c;
  localparam logic [7:0] PRE_PINS = {PRE[11], PRE[8], PRE[10], PRE[7],
    PRE[5], PRE[3], PRE[4], PRE[2]};
  localparam logic [11:0] INT_V = 12'h243;

  logic clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, wsel, wr, rd, b;
  logic [1:0] pad_in, core_in, core_out, core_oe, pad_out, pad_oe;
  logic [1:0] bi_in, core_bi_in, core_bi_out, core_bi_oe, bi_out, bi_oe;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic [31:0] got;
  // clamp, highz, bypass, then an undefined code that must act as bypass
  logic [3:0] codes [4] = '{4'h7, 4'h4, 4'hf, 4'ha};
  int err_count, n_compared;
  wire logic [7:0] pins = {bi_oe, bi_out, pad_oe, pad_out};
  wire logic [7:0] pins_core = {core_bi_oe, core_bi_out, core_oe, core_out};
  wire logic [11:0] cap_exp = {core_bi_oe[1], core_bi_out[1], bi_in[1],
    core_bi_oe[0], core_bi_out[0], bi_in[0], core_oe[1], core_out[1],
    core_oe[0], core_out[0], pad_in};

  boundary_scan_tap #(.ID_VERSION(VER), .ID_DEVICE(DEV), .ID_MFR(MFR))
  i_dut (.i_ref_clk(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_pad_in(pad_in), .o_core_in(core_in), .i_core_out(core_out),
    .i_core_oe(core_oe), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .i_pad_bi_in(bi_in), .o_core_bi_in(core_bi_in),
    .i_core_bi_out(core_bi_out), .i_core_bi_oe(core_bi_oe),
    .o_pad_bi_out(bi_out), .o_pad_bi_oe(bi_oe),
    .i_bus_width_select(wsel), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata));

  jtag_tester i_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_trst_n(trst_n), .i_tdo(tdo), .i_tdo_oe(tdo_oe));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // compare, report, processor port and scan helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  task automatic go_shift(input logic ir);
    i_tester.step(1'b1, 1'b0, b);
    if (ir) begin
      i_tester.step(1'b1, 1'b0, b);
    end
    i_tester.step(1'b0, 1'b0, b);
    i_tester.step(1'b0, 1'b0, b);
  endtask

  // shift n bits lsb first, then update and return to idle
  task automatic shift(input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic t;
    dout = '0;
    for (int k = 0; k < n; k++) begin
      i_tester.step(k == n - 1, din[k], t);
      dout[k] = t;
    end
    i_tester.step(1'b1, 1'b0, t);
    i_tester.step(1'b0, 1'b0, t);
  endtask

  task automatic load_ir(input logic [3:0] code);
    go_shift(1'b1);
    shift(4, {28'h0, code}, got);
    chk(got, 32'h1);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, wsel, wr, rd, addr, wdata} = {2'b10, 2'b00, 13'h0};
    {pad_in, bi_in, core_out, core_oe} = 8'h69;
    {core_bi_out, core_bi_oe} = 4'b0111;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    bus_rd(5'h1c, ID8);
    bus_rd(5'h1b, 8'hff);
    bus_rd(5'h05, 8'h00);
    chk(tdo_oe, 1'b0);
    wsel <= 1'b1;
    repeat (4) @(posedge clk);
    bus_wr(5'h1b, 8'h3c);
    bus_rd(5'h1c, ID8);
    bus_rd(5'h1b, 8'h3c);
    rst <= 1'b1;
    wsel <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    bus_wr(5'h1c, 8'haa);
    bus_rd(5'h1c, ID8);
    bus_wr(5'h1b, 8'h55);
    bus_rd(5'h1c, 8'h00);
    bus_rd(5'h1b, 8'h55);
    #13;
    i_tester.step(1'b0, 1'b0, b);
    go_shift(1'b0);
    shift(32, 32'h0, got);
    chk(got, ID_EXP);
    chk(tdo_oe, 1'b0);
    load_ir(4'h5);
    go_shift(1'b0);
    shift(12, {20'h0, PRE}, got);
    chk(got, {20'h0, cap_exp});
    chk({core_in, pins}, {pad_in, pins_core});
    @(posedge clk);
    {pad_in, bi_in} <= 4'b1001;
    load_ir(4'h0);
    chk(pins, PRE_PINS);
    go_shift(1'b0);
    shift(12, {20'h0, PRE}, got);
    chk(got, {20'h0, cap_exp});
    foreach (codes[i]) begin
      load_ir(codes[i]);
      go_shift(1'b0);
      shift(8, 32'hb5, got);
      chk(got, 32'h6a);
      if (codes[i] == 4'h4) begin
        chk({bi_oe, pad_oe}, 32'h0);
      end else begin
        chk(pins, codes[i] == 4'h7 ? PRE_PINS : pins_core);
      end
    end
    load_ir(4'h6);
    go_shift(1'b0);
    shift(12, {20'h0, INT_V}, got);
    chk(got, {20'h0, cap_exp});
    chk({core_bi_in, core_in}, {INT_V[9], INT_V[6], INT_V[1:0]});
    go_shift(1'b0);
    i_tester.pulse_reset();
    chk(tdo_oe, 1'b0);
    chk(core_in, pad_in);
    i_tester.step(1'b0, 1'b0, b);
    go_shift(1'b0);
    shift(32, 32'h0, got);
    chk(got, ID_EXP);
    conclude();
  end
endmodule
